// [core/abr_defs.svh]
`ifndef ABR_DEFS_SVH
`define ABR_DEFS_SVH
// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define ABR_DATA_W   32
`define ABR_BADDR_W  17
`define ABR_WADDR_W  15
`define ABR_LANES    4
`define ABR_IDX_W    6
`define ABR_RAM_AW   13
// ----------------------------------------------------------------
// Byte address map
// ----------------------------------------------------------------
`define ABR_PARAM_HI 17'h000FF
`define ABR_STAT_LO  17'h00100
`define ABR_STAT_HI  17'h001FF
`define ABR_CPAR_LO  17'h00400
`define ABR_CPAR_HI  17'h004FF
`define ABR_CSTS_LO  17'h00500
`define ABR_CSTS_HI  17'h005FF
`define ABR_GEN_LO   17'h01000
`define ABR_GEN_HI   17'h01FFF
`define ABR_IDEN_LO  17'h10000
`define ABR_IDEN_HI  17'h17FFF
`define ABR_CRAM_LO  17'h18000
`define ABR_CRAM_HI  17'h1FFFF
// ----------------------------------------------------------------
// Answers and timing
// ----------------------------------------------------------------
`define ABR_RESP_OKAY 2'h0
`define ABR_RD_LAT    3
`endif

// [core/abr_pkg.sv]
`include "abr_defs.svh"
package abr_pkg;
  typedef logic [`ABR_DATA_W-1:0]  abr_word_t;
  typedef logic [`ABR_BADDR_W-1:0] abr_baddr_t;
  typedef logic [`ABR_WADDR_W-1:0] abr_waddr_t;
  typedef logic [`ABR_LANES-1:0]   abr_lanes_t;
  typedef logic [`ABR_IDX_W-1:0]   abr_idx_t;
  // Bridge sequencing
  typedef enum logic [1:0] {
    ABR_IDLE    = 2'b00,
    ABR_WR_RESP = 2'b01,
    ABR_RD_WAIT = 2'b10,
    ABR_RD_RESP = 2'b11
  } abr_state_e;
endpackage

// [core/abr_ram_if.sv]
`timescale 1ns/10ps
interface abr_ram_if #(parameter int AW = 13);
  logic                 wr_en;
  logic [AW-1:0]        addr;
  abr_pkg::abr_word_t   wr_word;
  abr_pkg::abr_word_t   rd_word;
  modport mem  (input wr_en, addr, wr_word, output rd_word);
  modport user (output wr_en, addr, wr_word, input rd_word);
endinterface

// [core/abr_sync2.sv]
`timescale 1ns/10ps
module abr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Foreign level in, local level out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  // Two flops; only the second is read outside
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule // abr_sync2

// [core/abr_word_ram.sv]
`timescale 1ns/10ps
module abr_word_ram #(
  parameter int AW = 13
) (
  // Clock
  input  wire logic clk_in,
  // Memory port
  abr_ram_if.mem    port_io
);
  import abr_pkg::*;
  localparam int DEPTH = 1 << AW;

  abr_word_t mem_q [DEPTH];
  abr_word_t rd_q;

  generate
    if (AW < 1 || AW > `ABR_RAM_AW) begin : g_bad_aw
      $error("abr_word_ram: AW out of range");
    end
  endgenerate

  // Write-first is not needed: reads and writes never share a cycle
  always_ff @(posedge clk_in) begin
    if (port_io.wr_en) begin
      mem_q[port_io.addr] <= port_io.wr_word;
    end
    rd_q <= mem_q[port_io.addr];
  end

  assign port_io.rd_word = rd_q;
endmodule // abr_word_ram

// [core/abr_bus_register_wrapper.sv]
`timescale 1ns/10ps
`include "abr_defs.svh"
module abr_bus_register_wrapper #(
  parameter int RAM_AW = `ABR_RAM_AW
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // Processor bus, timed by the processor clock
  input  wire logic                 processor_clock_in,
  input  wire logic                 s_axi_awvalid_in,
  input  wire abr_pkg::abr_baddr_t  s_axi_awaddr_in,
  output logic                      s_axi_awready_out,
  input  wire logic                 s_axi_wvalid_in,
  input  wire abr_pkg::abr_word_t   s_axi_wdata_in,
  input  wire abr_pkg::abr_lanes_t  s_axi_wstrb_in,
  output logic                      s_axi_wready_out,
  output logic                      s_axi_bvalid_out,
  output logic [1:0]                s_axi_bresp_out,
  input  wire logic                 s_axi_bready_in,
  input  wire logic                 s_axi_arvalid_in,
  input  wire abr_pkg::abr_baddr_t  s_axi_araddr_in,
  output logic                      s_axi_arready_out,
  output logic                      s_axi_rvalid_out,
  output abr_pkg::abr_word_t        s_axi_rdata_out,
  output logic [1:0]                s_axi_rresp_out,
  input  wire logic                 s_axi_rready_in,
  // Register interface tap
  output abr_pkg::abr_waddr_t       reg_word_address_out,
  output logic                      reg_write_strobe_out,
  output abr_pkg::abr_word_t        reg_write_word_out,
  output abr_pkg::abr_lanes_t       reg_byte_lane_mask_out,
  output logic                      reg_read_request_out,
  output logic                      reg_read_valid_out,
  // Write-only parameter areas
  output logic                      param_write_out,
  output logic                      custom_param_write_out,
  output abr_pkg::abr_idx_t         param_index_out,
  output abr_pkg::abr_word_t        param_word_out,
  // Status words, registered by each source one cycle after address
  input  wire abr_pkg::abr_word_t   ctrl_status_in,
  input  wire abr_pkg::abr_word_t   custom_status_in,
  input  wire abr_pkg::abr_word_t   gen_status_in,
  input  wire abr_pkg::abr_word_t   iden_data_in
);
  import abr_pkg::*;

  if (RAM_AW < 1 || RAM_AW > `ABR_RAM_AW) begin : g_bad_aw
    $error("abr_bus_register_wrapper: RAM_AW out of range");
  end

  // ----------------------------------------------------------------
  // Bus input sampling
  // ----------------------------------------------------------------
  localparam int CTL_W = 6;
  logic [CTL_W-1:0] ctl_s;
  abr_baddr_t       aw_addr_s;
  abr_baddr_t       ar_addr_s;
  abr_word_t        w_word_s;
  abr_lanes_t       w_mask_s;
  logic             pclk_seen_q;

  // One sampler for all bus inputs keeps clock and data equally delayed
  abr_sync2 #(.W(CTL_W + 2 * `ABR_BADDR_W + `ABR_LANES + `ABR_DATA_W)) u_sync_bus (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({processor_clock_in, s_axi_awvalid_in, s_axi_wvalid_in,
                s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in,
                s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in, s_axi_wdata_in}),
    .q_out    ({ctl_s, aw_addr_s, ar_addr_s, w_mask_s, w_word_s})
  );

  // Act at the processor clock's falling edge: inputs are mid-cycle
  // stable there, and outputs changed now settle before its next rise
  wire pclk_s    = ctl_s[5];
  wire awvalid_s = ctl_s[4];
  wire wvalid_s  = ctl_s[3];
  wire bready_s  = ctl_s[2];
  wire arvalid_s = ctl_s[1];
  wire rready_s  = ctl_s[0];
  wire bus_ev    = pclk_seen_q & ~pclk_s;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pclk_seen_q <= 1'b0;
    end else begin
      pclk_seen_q <= pclk_s;
    end
  end

  // ----------------------------------------------------------------
  // Bus channels
  // ----------------------------------------------------------------
  abr_state_e state_q;
  abr_state_e state_d;
  logic       aw_full_q;
  logic       w_full_q;
  logic       ar_full_q;
  logic       bvalid_q;
  logic       rvalid_q;
  abr_baddr_t aw_addr_q;
  abr_baddr_t ar_addr_q;
  abr_word_t  w_word_q;
  abr_lanes_t w_mask_q;
  abr_word_t  rdata_q;
  logic       aw_hold_q, w_hold_q, ar_hold_q, b_hs_q, r_hs_q;

  // Channel handshakes, each one bus edge wide
  wire aw_take = bus_ev & awvalid_s & ~aw_full_q;
  wire w_take  = bus_ev & wvalid_s & ~w_full_q;
  wire ar_take = bus_ev & arvalid_s & ~ar_full_q;
  wire b_done  = bus_ev & b_hs_q;
  wire r_done  = bus_ev & r_hs_q;
  wire b_next  = (state_q == ABR_WR_RESP) & ~b_done;
  wire r_next  = (state_q == ABR_RD_RESP) & ~r_done;

  // Items are taken at a bus edge, but ready falls only at the next one,
  // so the master still sees it high at the rise that ends its handshake
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      {aw_full_q, w_full_q, ar_full_q} <= 3'b000;
      {aw_hold_q, w_hold_q, ar_hold_q} <= 3'b000;
      aw_addr_q <= '0;
      ar_addr_q <= '0;
      w_word_q  <= '0;
      w_mask_q  <= '0;
    end else begin
      aw_full_q <= aw_take | (aw_full_q & ~b_done);
      w_full_q  <= w_take | (w_full_q & ~b_done);
      ar_full_q <= ar_take | (ar_full_q & ~r_done);
      if (bus_ev) {aw_hold_q, w_hold_q, ar_hold_q} <= {aw_full_q, w_full_q, ar_full_q};
      if (aw_take) aw_addr_q <= aw_addr_s;
      if (ar_take) ar_addr_q <= ar_addr_s;
      if (w_take) begin
        w_word_q <= w_word_s;
        w_mask_q <= w_mask_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register side sequencing
  // ----------------------------------------------------------------
  abr_waddr_t addr_q;
  logic       strobe_q;
  abr_word_t  wword_q;
  abr_lanes_t mask_q;
  logic       req_q;
  logic [`ABR_RD_LAT-1:0] vld_q;
  abr_word_t  rd_q;
  abr_word_t  mux_q;

  // Writes win a tie; a waiting read still goes right after the one write ahead of it
  wire idle  = (state_q == ABR_IDLE);
  wire wr_go = idle & aw_full_q & w_full_q;
  wire rd_go = idle & ~wr_go & ar_full_q;
  wire rd_in = vld_q[`ABR_RD_LAT-1];

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ABR_IDLE: begin
        if (wr_go) state_d = ABR_WR_RESP;
        else if (rd_go) state_d = ABR_RD_WAIT;
      end
      ABR_WR_RESP: begin
        if (b_done) state_d = ABR_IDLE;
      end
      ABR_RD_WAIT: begin
        if (rd_in) state_d = ABR_RD_RESP;
      end
      ABR_RD_RESP: begin
        if (r_done) state_d = ABR_IDLE;
      end
      default: state_d = ABR_IDLE;
    endcase
  end

  // Answers move only at a bus edge; valid and ready seen there make the
  // handshake of the next rise, which the following bus edge then retires
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q  <= ABR_IDLE;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      {b_hs_q, r_hs_q} <= 2'b00;
    end else begin
      state_q  <= state_d;
      bvalid_q <= b_next & (bus_ev | bvalid_q);
      rvalid_q <= r_next & (bus_ev | rvalid_q);
      if (bus_ev) {b_hs_q, r_hs_q} <= {b_next & bready_s, r_next & rready_s};
      if (state_q == ABR_RD_WAIT && rd_in) rdata_q <= rd_q;
    end
  end

  // Shared address loads only when idle, so it holds through a read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      addr_q   <= '0;
      strobe_q <= 1'b0;
      wword_q  <= '0;
      mask_q   <= '0;
      req_q    <= 1'b0;
    end else begin
      if (wr_go) addr_q <= aw_addr_q[`ABR_BADDR_W-1:2];
      else if (rd_go) addr_q <= ar_addr_q[`ABR_BADDR_W-1:2];
      strobe_q <= wr_go;
      req_q    <= rd_go;
      if (wr_go) begin
        wword_q <= w_word_q;
        mask_q  <= w_mask_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // User register block: decode
  // ----------------------------------------------------------------
  wire abr_baddr_t ba = {addr_q, 2'b00};
  wire in_param = (ba <= `ABR_PARAM_HI);
  wire in_stat  = (ba >= `ABR_STAT_LO) && (ba <= `ABR_STAT_HI);
  wire in_cpar  = (ba >= `ABR_CPAR_LO) && (ba <= `ABR_CPAR_HI);
  wire in_csts  = (ba >= `ABR_CSTS_LO) && (ba <= `ABR_CSTS_HI);
  wire in_gen   = (ba >= `ABR_GEN_LO) && (ba <= `ABR_GEN_HI);
  wire in_iden  = (ba >= `ABR_IDEN_LO) && (ba <= `ABR_IDEN_HI);
  wire in_cram  = (ba >= `ABR_CRAM_LO) && (ba <= `ABR_CRAM_HI);

  // ----------------------------------------------------------------
  // User register block: writes, full words only
  // ----------------------------------------------------------------
  abr_ram_if #(.AW(RAM_AW)) ram_if ();
  logic      param_wr_q;
  logic      cpar_wr_q;
  abr_idx_t  pidx_q;
  abr_word_t pword_q;

  // Lane mask is tapped but never gates a write
  assign ram_if.wr_en   = strobe_q & in_cram;
  assign ram_if.addr    = addr_q[RAM_AW-1:0];
  assign ram_if.wr_word = wword_q;

  abr_word_ram #(.AW(RAM_AW)) u_cram (
    .clk_in  (clk_in),
    .port_io (ram_if.mem)
  );

  // Status and identify areas take no write effect
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      param_wr_q <= 1'b0;
      cpar_wr_q  <= 1'b0;
      pidx_q     <= '0;
      pword_q    <= '0;
    end else begin
      param_wr_q <= strobe_q & in_param;
      cpar_wr_q  <= strobe_q & in_cpar;
      if (strobe_q) begin
        pidx_q  <= addr_q[`ABR_IDX_W-1:0];
        pword_q <= wword_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // User register block: three-stage read path
  // ----------------------------------------------------------------
  // Stage one sits in each source; here the region picks one word
  wire abr_word_t sel_word = in_stat ? ctrl_status_in :
                             in_csts ? custom_status_in :
                             in_gen  ? gen_status_in :
                             in_iden ? iden_data_in :
                             in_cram ? ram_if.rd_word :
                             '0;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mux_q <= '0;
      rd_q  <= '0;
      vld_q <= '0;
    end else begin
      mux_q <= sel_word;
      rd_q  <= mux_q;
      vld_q <= {vld_q[`ABR_RD_LAT-2:0], req_q};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready_out      = ~aw_hold_q;
  assign s_axi_wready_out       = ~w_hold_q;
  assign s_axi_arready_out      = ~ar_hold_q;
  assign s_axi_bvalid_out       = bvalid_q;
  assign s_axi_bresp_out        = `ABR_RESP_OKAY;
  assign s_axi_rvalid_out       = rvalid_q;
  assign s_axi_rdata_out        = rdata_q;
  assign s_axi_rresp_out        = `ABR_RESP_OKAY;
  assign reg_word_address_out   = addr_q;
  assign reg_write_strobe_out   = strobe_q;
  assign reg_write_word_out     = wword_q;
  assign reg_byte_lane_mask_out = mask_q;
  assign reg_read_request_out   = req_q;
  assign reg_read_valid_out     = rd_in;
  assign param_write_out        = param_wr_q;
  assign custom_param_write_out = cpar_wr_q;
  assign param_index_out        = pidx_q;
  assign param_word_out         = pword_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_read_latency: assert property (req_q |-> ##3 rd_in)
    else $error("read valid not three cycles after request");
  a_valid_cause: assert property (rd_in |-> $past(req_q, 3))
    else $error("read valid without request");
  a_addr_held: assert property ((state_q == ABR_RD_WAIT) |=> $stable(addr_q))
    else $error("address moved during read");
  a_no_overlap: assert property (strobe_q |-> state_q == ABR_WR_RESP)
    else $error("write strobe outside write sequence");
  a_strobe_single: assert property (strobe_q |=> !strobe_q)
    else $error("write strobe longer than one cycle");
  a_bresp_bound: assert property (strobe_q |-> ##[1:60] bvalid_q)
    else $error("write answer missing");
  a_aw_blocked: assert property (bvalid_q |-> !s_axi_awready_out && $past(strobe_q) == 1'b0)
    else $error("write accepted before answer");
  a_param_area: assert property (strobe_q && in_param |=> param_wr_q && pidx_q == $past(addr_q[5:0]))
    else $error("parameter write lost");
  a_cpar_area: assert property (strobe_q && in_cpar |=> cpar_wr_q && pword_q == $past(wword_q))
    else $error("custom parameter write lost");
  a_status_nowrite: assert property (strobe_q && !in_param && !in_cpar |=> !param_wr_q && !cpar_wr_q)
    else $error("write reached a read-only area");
  a_ram_path: assert property (req_q && in_cram |-> ##3 rd_q == $past(ram_if.rd_word, 2))
    else $error("ram read word wrong");
  a_okay_resp: assert property (bvalid_q || rvalid_q |-> s_axi_bresp_out == `ABR_RESP_OKAY)
    else $error("answer not okay");

  c_write: cover property (strobe_q ##[1:60] b_done);
  c_read_iden: cover property (req_q && in_iden ##3 rd_in);
  c_read_cram: cover property (req_q && in_cram ##[3:60] r_done);
  c_wr_then_rd: cover property (b_done ##[1:20] req_q);
endmodule // abr_bus_register_wrapper

// [verif/abr_axi_master.sv]
`timescale 1ns/10ps
module abr_axi_master (
  // Bus clock
  input  wire logic                pclk_in,
  // Write side
  output logic                     awvalid_out,
  output abr_pkg::abr_baddr_t      awaddr_out,
  input  wire logic                awready_in,
  output logic                     wvalid_out,
  output abr_pkg::abr_word_t       wdata_out,
  output abr_pkg::abr_lanes_t      wstrb_out,
  input  wire logic                wready_in,
  input  wire logic                bvalid_in,
  input  wire logic [1:0]          bresp_in,
  output logic                     bready_out,
  // Read side
  output logic                     arvalid_out,
  output abr_pkg::abr_baddr_t      araddr_out,
  input  wire logic                arready_in,
  input  wire logic                rvalid_in,
  input  wire abr_pkg::abr_word_t  rdata_in,
  input  wire logic [1:0]          rresp_in,
  output logic                     rready_out
);
  import abr_pkg::*;
  int stall = 0; // Bus clocks the master waits before taking an answer
  // ----------------------------------------
  // Idle bus
  // ----------------------------------------
  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
    awaddr_out = 17'h00000;
    wdata_out = 32'h00000000;
    wstrb_out = 4'h0;
    araddr_out = 17'h00000;
  end
  // Word store; each channel drops once taken, released address and data go to the inverse
  task automatic wr(input abr_baddr_t a, input abr_word_t d, input abr_lanes_t s,
                    output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    @(posedge pclk_in);
    #1;
    {aw_ok, w_ok} = 2'b00;
    awaddr_out = a;
    wdata_out = d;
    wstrb_out = s;
    {awvalid_out, wvalid_out} = 2'b11;
    while (!(aw_ok && w_ok)) begin
      @(posedge pclk_in);
      aw_ok = aw_ok | (awready_in === 1'b1);
      w_ok = w_ok | (wready_in === 1'b1);
      #1;
      if (aw_ok) awvalid_out = 1'b0;
      if (aw_ok) awaddr_out = ~a;
      if (w_ok) wvalid_out = 1'b0;
      if (w_ok) wdata_out = ~d;
    end
    repeat (stall) @(posedge pclk_in);
    #1;
    bready_out = 1'b1;
    do @(posedge pclk_in); while (bvalid_in !== 1'b1);
    resp = bresp_in;
    #1;
    bready_out = 1'b0;
  endtask
  // Word load; address held until taken, data taken at the handshake edge
  task automatic rd(input abr_baddr_t a, output abr_word_t d, output logic [1:0] resp);
    @(posedge pclk_in);
    #1;
    araddr_out = a;
    arvalid_out = 1'b1;
    do @(posedge pclk_in); while (arready_in !== 1'b1);
    #1;
    arvalid_out = 1'b0;
    araddr_out = ~a;
    repeat (stall) @(posedge pclk_in);
    #1;
    rready_out = 1'b1;
    do @(posedge pclk_in); while (rvalid_in !== 1'b1);
    d = rdata_in;
    resp = rresp_in;
    #1;
    rready_out = 1'b0;
  endtask
endmodule // abr_axi_master

// [verif/tb_abr_bus_register_wrapper.sv]
`timescale 1ns/10ps
`include "abr_defs.svh"
module tb_abr_bus_register_wrapper;
  import abr_pkg::*;
  localparam int RAM_AW = 13;
  logic       clk = 1'b0, pclk = 1'b0, rst_n = 1'b0;
  logic       awvalid, awready, wvalid, wready, bvalid, bready;
  logic       arvalid, arready, rvalid, rready, wstrobe, rreq, rvld, ppulse, cpulse;
  logic [1:0] bresp, rresp, seen_area;
  logic [2:0] rpipe = 3'h0;
  abr_baddr_t awaddr, araddr;
  abr_word_t  wdata, rdata, wword, pword, seen_word, seen_pword;
  abr_word_t  ctrl_sts = '0, cust_sts = '0, gen_sts = '0, iden_sts = '0;
  abr_lanes_t wstrb, lanes, seen_lanes;
  abr_waddr_t waddr, seen_addr, raddr_q;
  abr_idx_t   pidx, seen_idx;
  int         mismatches = 0, checks_done = 0, cycles = 0;
  // ----------------------------------------
  // Clocks, sources and monitors
  // ----------------------------------------
  initial forever #2 clk = ~clk;
  // Bus clock starts off phase so no edge pairs up with the user clock
  initial begin
    #13;
    forever #40 pclk = ~pclk;
  end
  function automatic abr_word_t sts_of(input logic [7:0] t, input abr_waddr_t a);
    return {t, 9'h000, a};
  endfunction
  // Status sources answer one cycle after the address
  always @(posedge clk) begin
    ctrl_sts <= sts_of(8'hC1, waddr);
    cust_sts <= sts_of(8'hD2, waddr);
    gen_sts <= sts_of(8'hE3, waddr);
    iden_sts <= sts_of(8'hA4, waddr);
  end
  // Capture register-side writes; read valid must trail request by three cycles
  always @(posedge clk) begin
    if (wstrobe === 1'b1) {seen_addr, seen_word, seen_lanes} <= {waddr, wword, lanes};
    if ((ppulse | cpulse) === 1'b1) {seen_idx, seen_pword} <= {pidx, pword};
    if ((ppulse | cpulse) === 1'b1) seen_area <= {ppulse, cpulse};
    rpipe <= rst_n ? {rpipe[1:0], rreq === 1'b1} : 3'h0;
    if (rreq === 1'b1) raddr_q <= waddr;
    if (rst_n && (rpipe[2] || rvld === 1'b1)) begin
      check("read valid", 32'(rpipe[2]), 32'(rvld));
      check("read address", 32'(raddr_q), 32'(waddr));
    end
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  abr_bus_register_wrapper #(.RAM_AW(RAM_AW)) DUT (
    .clk_in(clk), .rst_n_in(rst_n), .processor_clock_in(pclk),
    .s_axi_awvalid_in(awvalid), .s_axi_awaddr_in(awaddr), .s_axi_awready_out(awready),
    .s_axi_wvalid_in(wvalid), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wready_out(wready), .s_axi_bvalid_out(bvalid), .s_axi_bresp_out(bresp),
    .s_axi_bready_in(bready), .s_axi_arvalid_in(arvalid), .s_axi_araddr_in(araddr),
    .s_axi_arready_out(arready), .s_axi_rvalid_out(rvalid), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rready_in(rready),
    .reg_word_address_out(waddr), .reg_write_strobe_out(wstrobe),
    .reg_write_word_out(wword), .reg_byte_lane_mask_out(lanes),
    .reg_read_request_out(rreq), .reg_read_valid_out(rvld),
    .param_write_out(ppulse), .custom_param_write_out(cpulse),
    .param_index_out(pidx), .param_word_out(pword),
    .ctrl_status_in(ctrl_sts), .custom_status_in(cust_sts),
    .gen_status_in(gen_sts), .iden_data_in(iden_sts));
  abr_axi_master u_master (
    .pclk_in(pclk), .awvalid_out(awvalid), .awaddr_out(awaddr), .awready_in(awready),
    .wvalid_out(wvalid), .wdata_out(wdata), .wstrb_out(wstrb), .wready_in(wready),
    .bvalid_in(bvalid), .bresp_in(bresp), .bready_out(bready),
    .arvalid_out(arvalid), .araddr_out(araddr), .arready_in(arready),
    .rvalid_in(rvalid), .rdata_in(rdata), .rresp_in(rresp), .rready_out(rready));
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus_wr(input abr_baddr_t a, input abr_word_t d, input abr_lanes_t s);
    logic [1:0] resp;
    u_master.wr(a, d, s, resp);
    check("write response", 32'(`ABR_RESP_OKAY), 32'(resp));
  endtask
  task automatic bus_rd(input abr_baddr_t a, input abr_word_t exp, input string what);
    abr_word_t  d;
    logic [1:0] resp;
    u_master.rd(a, d, resp);
    check("read response", 32'(`ABR_RESP_OKAY), 32'(resp));
    check(what, exp, d);
  endtask
  task automatic t_param(input abr_baddr_t a, input abr_lanes_t s, input logic [1:0] area);
    abr_word_t d;
    d = {a[15:0], 16'h5A3C};
    bus_wr(a, d, s);
    check("write address", 32'(a[16:2]), 32'(seen_addr));
    check("write word", d, seen_word);
    check("lane mask", 32'(s), 32'(seen_lanes));
    check("area pulse", 32'(area), 32'(seen_area));
    check("param index", 32'(a[7:2]), 32'(seen_idx));
    check("param word", d, seen_pword);
    bus_rd(a, 32'h00000000, "write-only readback");
    $display("test param write %h done", a);
  endtask
  task automatic t_status();
    abr_baddr_t a[6] = '{17'h00100, 17'h001FC, 17'h00504, 17'h01FFC, 17'h10000, 17'h17FFC};
    logic [7:0] t[6] = '{8'hC1, 8'hC1, 8'hD2, 8'hE3, 8'hA4, 8'hA4};
    foreach (a[i]) bus_rd(a[i], sts_of(t[i], a[i][16:2]), "status word");
    bus_rd(17'h02000, 32'h00000000, "unmapped word");
    bus_rd(17'h00600, 32'h00000000, "unmapped word");
    $display("test status reads done");
  endtask
  task automatic t_ram();
    u_master.stall = 2;
    bus_wr(17'h18000, 32'h1234ABCD, 4'h1);
    bus_wr(17'h1FFFC, 32'hC0FFEE55, 4'hF);
    bus_wr(17'h10004, 32'hDEADBEEF, 4'hF);
    bus_rd(17'h18000, 32'h1234ABCD, "ram low word");
    bus_rd(17'h1FFFC, 32'hC0FFEE55, "ram top word");
    bus_rd(17'h10004, sts_of(8'hA4, 15'h4001), "identify unchanged");
    u_master.stall = 0;
    $display("test ram window done");
  endtask
  task automatic t_overlap();
    fork
      bus_wr(17'h18020, 32'h0F1E2D3C, 4'hF);
      bus_rd(17'h00104, sts_of(8'hC1, 15'h0041), "status during write");
    join
    bus_rd(17'h18020, 32'h0F1E2D3C, "ram after overlap");
    $display("test overlap done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence; the bus waits a few cycles after reset for the samplers to settle
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("idle readies", 32'h7, 32'({awready, wready, arready}));
    check("idle valids", 32'h0, 32'({bvalid, rvalid, wstrobe, rreq}));
    $display("test reset done");
    t_param(17'h00008, 4'hF, 2'b10);
    t_param(17'h000FC, 4'h1, 2'b10);
    t_param(17'h00400, 4'h8, 2'b01);
    t_param(17'h004FC, 4'h3, 2'b01);
    t_status();
    t_ram();
    t_overlap();
    stop_test();
  end
endmodule // tb_abr_bus_register_wrapper
